// >>> hdl/sff_ingress.sv
// per-port store-and-forward ingress with buffer-based flow control
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps

// Overview of operation
// - whole frame stored and checked before forwarding
// - forward only legal length, good crc frames
// - buffer low sends pause on full duplex
// - buffer low forces collision on receiving half duplex
// - throttling ends once buffer space recovers
// - flow control enable gates pause and collision
// - tagged frames ranked by their priority field
// - eight priorities map onto two queues by table
// - receive and forward run concurrently, never blocking
module sff_ingress
    import sff_pkg::*;
#(
    parameter int ADDR_W = 11,
    parameter int DESC_W = 3
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    input wire logic rx_err,
    output logic out_valid,
    output logic [7:0] out_data,
    output logic out_last,
    output logic out_queue,
    input wire logic out_ready,
    output logic pause_req,
    output logic [15:0] pause_quanta,
    output logic force_col,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata
);
    import sff_pkg::*;

    localparam int PTR_W = ADDR_W + 1;
    localparam int DEPTH = 1 << ADDR_W;
    localparam int NDESC = 1 << DESC_W;

    function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
        return p + PTR_W'(1);
    endfunction

    // frame store: bit 8 marks the last byte of a frame
    logic [8:0] mem [0:DEPTH-1];
    logic dsc_q [0:NDESC-1];

    // registers
    logic fc_en;
    logic fdx;
    logic [15:0] low_thr;
    logic [15:0] high_thr;
    logic [7:0] prio_map;
    logic [15:0] pause_time;
    logic [15:0] good_cnt;
    logic [15:0] drop_cnt;

    // pointers
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] commit_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [DESC_W:0] dsc_wr;
    logic [DESC_W:0] dsc_rd;

    // receive frame state
    sff_rx_t rx_state;
    logic [11:0] fr_len;
    logic fr_ovf;
    logic fr_err;
    logic tpid_hi_ok;
    logic fr_tagged;
    logic [2:0] fr_pcp;

    // read side
    logic fv;
    logic [9:0] f_word;
    logic sk_in_ready;
    logic [9:0] sk_out;

    // flow control
    logic buf_low;

    // buffer occupancy
    wire [PTR_W-1:0] buf_used = wr_ptr - rd_ptr;
    wire [PTR_W-1:0] buf_free = PTR_W'(DEPTH) - buf_used;
    wire room = (buf_free != '0);
    wire [DESC_W:0] dsc_used = dsc_wr - dsc_rd;
    wire dsc_full = (dsc_used == (DESC_W + 1)'(NDESC));
    wire [15:0] free16 = 16'(buf_free);

    // receive decode
    wire rx_first = (rx_state == SFF_RX_IDLE);
    wire [11:0] byte_idx = rx_first ? 12'h000 : fr_len;
    wire [11:0] len_now = (byte_idx == SFF_LEN_SAT) ? SFF_LEN_SAT : byte_idx + 12'h001;
    wire store = rx_valid & room;
    wire crc_ok;
    wire tagged_now = fr_tagged & ~rx_first;
    wire [11:0] max_len = tagged_now ? SFF_MAX_LEN_TAG : SFF_MAX_LEN;
    wire len_ok = (len_now >= SFF_MIN_LEN) && (len_now <= max_len);
    wire ovf_now = (fr_ovf & ~rx_first) | ~room;
    wire err_now = (fr_err & ~rx_first) | rx_err;
    // collision fragments fail length or crc and are dropped here
    wire frame_good = ~err_now & ~ovf_now & crc_ok & len_ok & ~dsc_full;
    wire frame_end = rx_valid & rx_last;
    wire commit = frame_end & frame_good;
    wire discard = frame_end & ~frame_good;
    wire fr_queue = tagged_now ? prio_map[fr_pcp] : 1'b0;

    // a rejected frame is unwound to the last committed boundary
    wire [PTR_W-1:0] next_wr_ptr = discard ? commit_ptr : (store ? ptr_inc(wr_ptr) : wr_ptr);

    // read side: only committed bytes are ever fetched
    wire rd_avail = (rd_ptr != commit_ptr);
    wire fetch = rd_avail & (~fv | sk_in_ready);
    wire [8:0] rd_word = mem[rd_ptr[ADDR_W-1:0]];
    wire rd_queue = dsc_q[dsc_rd[DESC_W-1:0]];

    // hysteresis on the low flag
    wire low_set = ~buf_low & (free16 < low_thr);
    wire low_clr = buf_low & (free16 > high_thr);
    wire fc_fdx = fc_en & fdx;
    wire fc_hdx = fc_en & ~fdx;
    wire rx_busy = (rx_state == SFF_RX_BODY) | rx_valid;

    // register decode
    wire sel_ctrl = (reg_addr == SFF_REG_CTRL);
    wire sel_low = (reg_addr == SFF_REG_LOW_THR);
    wire sel_high = (reg_addr == SFF_REG_HIGH_THR);
    wire sel_map = (reg_addr == SFF_REG_PRIO_MAP);
    wire sel_stat = (reg_addr == SFF_REG_STATUS);
    wire sel_good = (reg_addr == SFF_REG_GOOD_CNT);
    wire sel_drop = (reg_addr == SFF_REG_DROP_CNT);
    wire sel_ptime = (reg_addr == SFF_REG_PAUSE_TIME);
    wire [31:0] ctrl_word = {30'h0, fdx, fc_en};
    wire [31:0] stat_word = {free16, 15'h0, buf_low};
    wire [31:0] rd_mux;

    assign rd_mux = sel_ctrl ? ctrl_word :
                    sel_low ? {16'h0000, low_thr} :
                    sel_high ? {16'h0000, high_thr} :
                    sel_map ? {24'h000000, prio_map} :
                    sel_stat ? stat_word :
                    sel_good ? {16'h0000, good_cnt} :
                    sel_drop ? {16'h0000, drop_cnt} :
                    sel_ptime ? {16'h0000, pause_time} :
                    32'h00000000;

    sff_crc u_crc (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .byte_en(rx_valid),
        .first(rx_first),
        .data(rx_data),
        .match(crc_ok)
    );

    sff_skid #(.W(10)) u_skid (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .in_valid(fv),
        .in_data(f_word),
        .in_ready(sk_in_ready),
        .out_valid(out_valid),
        .out_data(sk_out),
        .out_ready(out_ready)
    );

    assign out_data = sk_out[7:0];
    assign out_last = sk_out[8];
    assign out_queue = sk_out[9];

    // software registers
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            fc_en <= SFF_FC_EN_RST;
            fdx <= SFF_FDX_RST;
            low_thr <= SFF_LOW_THR_RST;
            high_thr <= SFF_HIGH_THR_RST;
            prio_map <= SFF_PRIO_MAP_RST;
            pause_time <= SFF_PAUSE_TIME_RST;
        end else if (reg_wr) begin
            if (sel_ctrl) begin
                fc_en <= reg_wdata[SFF_CTRL_FC_EN];
                fdx <= reg_wdata[SFF_CTRL_FDX];
            end else if (sel_low) begin
                low_thr <= reg_wdata[15:0];
            end else if (sel_high) begin
                high_thr <= reg_wdata[15:0];
            end else if (sel_map) begin
                prio_map <= reg_wdata[7:0];
            end else if (sel_ptime) begin
                pause_time <= reg_wdata[15:0];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

    // frame store writes
    always_ff @(posedge ref_clk) begin
        if (store) begin
            mem[wr_ptr[ADDR_W-1:0]] <= {rx_last, rx_data};
        end
        if (commit) begin
            dsc_q[dsc_wr[DESC_W-1:0]] <= fr_queue;
        end
    end

    // receive side bookkeeping
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rx_state <= SFF_RX_IDLE;
            wr_ptr <= '0;
            commit_ptr <= '0;
            dsc_wr <= '0;
            fr_len <= 12'h000;
            fr_ovf <= 1'b0;
            fr_err <= 1'b0;
            tpid_hi_ok <= 1'b0;
            fr_tagged <= 1'b0;
            fr_pcp <= 3'h0;
            good_cnt <= 16'h0000;
            drop_cnt <= 16'h0000;
        end else begin
            wr_ptr <= next_wr_ptr;
            if (rx_valid) begin
                fr_len <= len_now;
                fr_ovf <= ovf_now;
                fr_err <= err_now;
                if (byte_idx == SFF_TPID_HI_IDX) begin
                    tpid_hi_ok <= (rx_data == SFF_TPID_HI);
                end
                if (rx_first) begin
                    fr_tagged <= 1'b0;
                end else if (byte_idx == SFF_TPID_LO_IDX) begin
                    fr_tagged <= tpid_hi_ok & (rx_data == SFF_TPID_LO);
                end
                if (byte_idx == SFF_TCI_IDX) begin
                    fr_pcp <= rx_data[SFF_PCP_MSB:SFF_PCP_LSB];
                end
            end
            case (rx_state)
                SFF_RX_IDLE: begin
                    if (rx_valid & ~rx_last) begin
                        rx_state <= SFF_RX_BODY;
                    end
                end
                SFF_RX_BODY: begin
                    if (frame_end) begin
                        rx_state <= SFF_RX_IDLE;
                    end
                end
                default: begin
                    rx_state <= SFF_RX_IDLE;
                end
            endcase
            if (commit) begin
                commit_ptr <= ptr_inc(wr_ptr);
                dsc_wr <= dsc_wr + (DESC_W + 1)'(1);
                good_cnt <= good_cnt + 16'h0001;
            end
            if (discard) begin
                drop_cnt <= drop_cnt + 16'h0001;
            end
        end
    end

    // read side feeds the two-entry buffer
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rd_ptr <= '0;
            dsc_rd <= '0;
            fv <= 1'b0;
            f_word <= 10'h0;
        end else if (fetch) begin
            f_word <= {rd_queue, rd_word};
            fv <= 1'b1;
            rd_ptr <= ptr_inc(rd_ptr);
            if (rd_word[8]) begin
                dsc_rd <= dsc_rd + (DESC_W + 1)'(1);
            end
        end else if (sk_in_ready) begin
            fv <= 1'b0;
        end
    end

    // flow control
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            buf_low <= 1'b0;
            pause_req <= 1'b0;
            pause_quanta <= 16'h0000;
            force_col <= 1'b0;
        end else begin
            if (low_set) begin
                buf_low <= 1'b1;
            end else if (low_clr) begin
                buf_low <= 1'b0;
            end
            // a zero-time pause on recovery lets the partner resume at once
            pause_req <= fc_fdx & (low_set | low_clr);
            if (fc_fdx & low_set) begin
                pause_quanta <= pause_time;
            end else if (fc_fdx & low_clr) begin
                pause_quanta <= 16'h0000;
            end
            force_col <= fc_hdx & buf_low & ~low_clr & rx_busy;
        end
    end
endmodule

// >>> hdl/sff_pkg.sv
// constants shared by the store-and-forward ingress block
package sff_pkg;

    // register word offsets (byte addresses on the register port)
    localparam logic [7:0] SFF_REG_CTRL = 8'h00;
    localparam logic [7:0] SFF_REG_LOW_THR = 8'h04;
    localparam logic [7:0] SFF_REG_HIGH_THR = 8'h08;
    localparam logic [7:0] SFF_REG_PRIO_MAP = 8'h0c;
    localparam logic [7:0] SFF_REG_STATUS = 8'h10;
    localparam logic [7:0] SFF_REG_GOOD_CNT = 8'h14;
    localparam logic [7:0] SFF_REG_DROP_CNT = 8'h18;
    localparam logic [7:0] SFF_REG_PAUSE_TIME = 8'h1c;

    // control field positions
    localparam int SFF_CTRL_FC_EN = 0;
    localparam int SFF_CTRL_FDX = 1;

    // reset values
    localparam logic SFF_FC_EN_RST = 1'b1;
    localparam logic SFF_FDX_RST = 1'b1;
    localparam logic [15:0] SFF_LOW_THR_RST = 16'h0200;
    localparam logic [15:0] SFF_HIGH_THR_RST = 16'h0400;
    localparam logic [7:0] SFF_PRIO_MAP_RST = 8'hf0;
    localparam logic [15:0] SFF_PAUSE_TIME_RST = 16'hffff;

    // frame length limits in bytes, fcs included
    localparam logic [11:0] SFF_MIN_LEN = 12'h040;
    localparam logic [11:0] SFF_MAX_LEN = 12'h5ee;
    localparam logic [11:0] SFF_MAX_LEN_TAG = 12'h5f2;
    localparam logic [11:0] SFF_LEN_SAT = 12'hfff;

    // vlan tag position and identifier
    localparam logic [11:0] SFF_TPID_HI_IDX = 12'h00c;
    localparam logic [11:0] SFF_TPID_LO_IDX = 12'h00d;
    localparam logic [11:0] SFF_TCI_IDX = 12'h00e;
    localparam logic [7:0] SFF_TPID_HI = 8'h81;
    localparam logic [7:0] SFF_TPID_LO = 8'h00;
    localparam int SFF_PCP_MSB = 7;
    localparam int SFF_PCP_LSB = 5;

    // reflected crc-32
    localparam logic [31:0] SFF_CRC_INIT = 32'hffffffff;
    localparam logic [31:0] SFF_CRC_POLY = 32'hedb88320;
    localparam logic [31:0] SFF_CRC_RESIDUE = 32'hdebb20e3;

    // receive state
    typedef enum logic [1:0] {
        SFF_RX_IDLE = 2'b01,
        SFF_RX_BODY = 2'b10
    } sff_rx_t;

endpackage

// >>> hdl/sff_crc.sv
// running crc-32 over received bytes with residue check
`timescale 1ns/1ps
module sff_crc
    import sff_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic byte_en,
    input wire logic first,
    input wire logic [7:0] data,
    output logic match
);
    logic [31:0] crc;
    logic [31:0] next_crc;

    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ SFF_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    assign next_crc = crc_byte(first ? SFF_CRC_INIT : crc, data);
    // check includes the byte now arriving, so the last byte can be judged at once
    assign match = (next_crc == SFF_CRC_RESIDUE);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            crc <= SFF_CRC_INIT;
        end else if (byte_en) begin
            crc <= next_crc;
        end
    end
endmodule

// >>> hdl/sff_skid.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module sff_skid #(
    parameter int W = 10
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    logic v1;
    logic [W-1:0] d1;
    logic push;
    logic pop;

    assign in_ready = ~v1;
    assign push = in_valid & ~v1;
    assign pop = out_valid & out_ready;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            out_valid <= 1'b0;
            v1 <= 1'b0;
            out_data <= '0;
            d1 <= '0;
        end else if (pop) begin
            if (v1) begin
                out_data <= d1;
                v1 <= push;
                if (push) begin
                    d1 <= in_data;
                end
            end else begin
                out_valid <= push;
                if (push) begin
                    out_data <= in_data;
                end
            end
        end else if (push) begin
            if (out_valid) begin
                d1 <= in_data;
                v1 <= 1'b1;
            end else begin
                out_data <= in_data;
                out_valid <= 1'b1;
            end
        end
    end
endmodule

// >>> sim/sff_ingress_props.sv
// pin-level assertions for the store-and-forward ingress port
`timescale 1ns/1ps
module sff_ingress_props
    import sff_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic rx_valid,
    input wire logic rx_last,
    input wire logic out_valid,
    input wire logic [7:0] out_data,
    input wire logic out_last,
    input wire logic out_queue,
    input wire logic out_ready,
    input wire logic pause_req,
    input wire logic [15:0] pause_quanta,
    input wire logic force_col,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr
);
    logic fc_en, fdx, in_frame, paused_h;
    logic [15:0] pt;
    logic [11:0] pend;
    wire ctrl_wr = reg_wr && reg_addr == SFF_REG_CTRL;
    wire pt_wr = reg_wr && reg_addr == SFF_REG_PAUSE_TIME;
    wire rx_end = rx_valid && rx_last;
    wire out_end = out_valid && out_ready && out_last;
    // pend counts dropped frames too, so it only catches output before the first dropped frame ends
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            fc_en <= SFF_FC_EN_RST;
            fdx <= SFF_FDX_RST;
            pt <= SFF_PAUSE_TIME_RST;
            in_frame <= 1'b0;
            paused_h <= 1'b0;
            pend <= 12'h000;
        end else begin
            if (ctrl_wr) fc_en <= reg_wdata[SFF_CTRL_FC_EN];
            if (ctrl_wr) fdx <= reg_wdata[SFF_CTRL_FDX];
            if (pt_wr) pt <= reg_wdata[15:0];
            if (rx_valid) in_frame <= !rx_last;
            if (pause_req) paused_h <= !paused_h;
            pend <= pend + {11'h0, rx_end} - {11'h0, out_end};
        end
    end
    property p_hold;
        @(posedge ref_clk) disable iff (sys_rst)
        out_valid && !out_ready |=> out_valid && $stable({out_data, out_last, out_queue});
    endproperty
    a_hold: assert property (p_hold) else $error("output changed while stalled");
    property p_pulse;
        @(posedge ref_clk) disable iff (sys_rst) pause_req |=> !pause_req;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pause request longer than one cycle");
    property p_no_pause;
        @(posedge ref_clk) disable iff (sys_rst) !fc_en || !fdx |-> !pause_req;
    endproperty
    a_no_pause: assert property (p_no_pause) else $error("pause while not allowed");
    property p_no_col;
        @(posedge ref_clk) disable iff (sys_rst) !fc_en || fdx |-> !force_col;
    endproperty
    a_no_col: assert property (p_no_col) else $error("collision while not allowed");
    property p_col_rx;
        @(posedge ref_clk) disable iff (sys_rst) force_col |-> $past(rx_valid) || $past(in_frame);
    endproperty
    a_col_rx: assert property (p_col_rx) else $error("collision on an idle port");
    property p_q_on;
        @(posedge ref_clk) disable iff (sys_rst) pause_req && !paused_h |-> pause_quanta == pt;
    endproperty
    a_q_on: assert property (p_q_on) else $error("wrong pause time on entry");
    property p_q_off;
        @(posedge ref_clk) disable iff (sys_rst) pause_req && paused_h |-> pause_quanta == 16'h0000;
    endproperty
    a_q_off: assert property (p_q_off) else $error("resume pause not zero");
    property p_first;
        @(posedge ref_clk) disable iff (sys_rst) out_valid |-> pend != 12'h000;
    endproperty
    a_first: assert property (p_first) else $error("output before a frame ended");
endmodule

bind sff_ingress sff_ingress_props sff_ingress_props_i (.ref_clk, .sys_rst, .rx_valid, .rx_last,
    .out_valid, .out_data, .out_last, .out_queue, .out_ready, .pause_req, .pause_quanta,
    .force_col, .reg_addr, .reg_wdata, .reg_wr);

// >>> sim/sff_link_partner.sv
// behavioural ethernet station sending frames into the port
`timescale 1ns/1ps
module sff_link_partner (
    input wire logic ref_clk,
    input wire logic pause_req,
    input wire logic [15:0] pause_quanta,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last,
    output logic rx_err
);
    logic [9:0] exp_q[$];
    logic paused = 1'b0;
    logic [7:0] data_r = 8'h00;
    logic [7:0] idle_r = 8'h00;
    initial begin
        rx_valid = 1'b0;
        rx_last = 1'b0;
        rx_err = 1'b0;
    end
    // idle data keeps moving so a stale byte cannot pass for a good one
    always @(posedge ref_clk) idle_r <= idle_r + 8'h35;
    assign rx_data = rx_valid ? data_r : idle_r;
    always @(posedge ref_clk) if (pause_req) paused <= pause_quanta != 16'h0000;
    task automatic send(input int len, input bit tag, input logic [2:0] pcp, input int kind,
                        input bit good, input logic q);
        logic [7:0] b[2048];
        logic [31:0] crc;
        crc = 32'hffffffff;
        while (paused) @(posedge ref_clk);
        for (int i = 0; i < len; i++) begin
            if (i < len - 4) begin
                b[i] = (i == 12) ? (tag ? 8'h81 : 8'h08) : (i == 13) ? 8'h00 :
                       (tag && i == 14) ? {pcp, 5'h00} : 8'($urandom);
                crc ^= {24'h0, b[i]};
                repeat (8) crc = crc[0] ? (crc >> 1) ^ 32'hedb88320 : crc >> 1;
            end else begin
                b[i] = ~crc[8 * (i - len + 4) +: 8];
            end
        end
        if (kind == 1) b[len - 1] = ~b[len - 1];
        for (int i = 0; i < len; i++) begin
            @(posedge ref_clk);
            rx_valid <= 1'b1;
            data_r <= b[i];
            rx_last <= i == len - 1;
            rx_err <= kind == 2 && i == 20;
            if (good) exp_q.push_back({i == len - 1, q, b[i]});
        end
        @(posedge ref_clk);
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        rx_err <= 1'b0;
    endtask
endmodule

// >>> sim/tb.sv
// self-checking bench for the store-and-forward ingress port
`timescale 1ns/1ps
module tb;
    import sff_pkg::*;
    logic ref_clk = 1'b0, sys_rst = 1'b1, out_ready = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic rd_d = 1'b0, stall = 1'b0, saw_col = 1'b0;
    logic [7:0] reg_addr = 8'h00, map = SFF_PRIO_MAP_RST;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic rx_valid, rx_last, rx_err, out_valid, out_last, out_queue, pause_req, force_col;
    logic [7:0] rx_data, out_data;
    logic [15:0] pause_quanta;
    logic [31:0] rq[$];
    int miscompares = 0, n_tests = 0, n_pause = 0, n_good = 0, n_drop = 0, p0;
    int lens[7] = '{63, 64, 100, 1518, 1519, 1522, 1523};
    int kinds[7] = '{0, 1, 2, 0, 0, 0, 0};
    bit tags[7] = '{0, 0, 0, 0, 0, 1, 1};
    bit goods[7] = '{0, 0, 0, 1, 0, 1, 0};
    sff_ingress sff_ingress_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_last(rx_last), .rx_err(rx_err), .out_valid(out_valid),
        .out_data(out_data), .out_last(out_last), .out_queue(out_queue), .out_ready(out_ready),
        .pause_req(pause_req), .pause_quanta(pause_quanta), .force_col(force_col),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    sff_link_partner sff_link_partner_i (.ref_clk(ref_clk), .pause_req(pause_req),
        .pause_quanta(pause_quanta), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_last(rx_last), .rx_err(rx_err));
    initial forever #20 ref_clk = ~ref_clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // results are sampled before this edge's updates land
    always @(posedge ref_clk) begin
        if (rd_d) check(reg_rdata, rq.pop_front());
        if (out_valid && out_ready) check({22'h0, out_last, out_queue, out_data},
            {22'h0, sff_link_partner_i.exp_q.pop_front()});
        if (pause_req) n_pause++;
        if (force_col) saw_col = 1'b1;
        rd_d <= reg_rd;
        out_ready <= !stall && ($urandom % 4 != 0);
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        rq.push_back(e);
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask
    task automatic frame(input int len, input bit tag, input logic [2:0] pcp, input int kind,
                         input bit good);
        if (good) n_good++;
        else n_drop++;
        sff_link_partner_i.send(len, tag, pcp, kind, good, tag ? map[pcp] : 1'b0);
    endtask
    task automatic wait_q(input int n);
        for (int i = 0; i < 8000 && sff_link_partner_i.exp_q.size() > n; i++) @(posedge ref_clk);
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic drain();
        stall = 1'b0;
        wait_q(0);
        rd(SFF_REG_STATUS, 32'h08000000);
    endtask
    task automatic stalled_pair();
        p0 = n_pause;
        saw_col = 1'b0;
        stall = 1'b1;
        frame(150, 0, 3'h0, 0, 1);
        frame(150, 0, 3'h0, 0, 1);
    endtask
    initial begin
        #(40 * 60000);
        miscompares++;
        report_and_stop();
    end
    initial begin
        void'($urandom(94));
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(SFF_REG_CTRL, {30'h0, SFF_FDX_RST, SFF_FC_EN_RST});
        rd(SFF_REG_LOW_THR, {16'h0, SFF_LOW_THR_RST});
        rd(SFF_REG_HIGH_THR, {16'h0, SFF_HIGH_THR_RST});
        rd(SFF_REG_PRIO_MAP, {24'h0, SFF_PRIO_MAP_RST});
        rd(SFF_REG_PAUSE_TIME, {16'h0, SFF_PAUSE_TIME_RST});
        rd(8'h20, 32'h0);
        $display("test reset values done");
        map = 8'($urandom);
        wr(SFF_REG_PRIO_MAP, {24'h0, map});
        for (int p = 0; p < 8; p++) frame(64, 1, 3'(p), 0, 1);
        frame(64, 0, 3'h7, 0, 1);
        drain();
        $display("test priority queues done");
        for (int i = 0; i < 7; i++) begin
            frame(lens[i], tags[i], 3'h3, kinds[i], goods[i]);
            drain();
        end
        $display("test length and crc filtering done");
        wr(SFF_REG_LOW_THR, 32'h700);
        wr(SFF_REG_HIGH_THR, 32'h7c0);
        wr(SFF_REG_PAUSE_TIME, {16'h0, 16'($urandom) | 16'h0001});
        stalled_pair();
        stall = 1'b0;
        wait_q(150);
        stall = 1'b1;
        check(32'(n_pause), 32'(p0 + 1));
        drain();
        check(32'(n_pause), 32'(p0 + 2));
        $display("test full duplex pause done");
        wr(SFF_REG_CTRL, 32'h1);
        stalled_pair();
        repeat (4) @(posedge ref_clk);
        check({31'h0, saw_col}, 32'h1);
        check(32'(n_pause), 32'(p0));
        drain();
        $display("test half duplex collision done");
        wr(SFF_REG_CTRL, 32'h0);
        stalled_pair();
        repeat (4) @(posedge ref_clk);
        check({31'h0, saw_col}, 32'h0);
        check(32'(n_pause), 32'(p0));
        drain();
        rd(SFF_REG_GOOD_CNT, 32'(n_good));
        rd(SFF_REG_DROP_CNT, 32'(n_drop));
        repeat (2) @(posedge ref_clk);
        $display("test flow control disabled done");
        report_and_stop();
    end
endmodule
